// ### rtl/pmc_params.svh
// register offsets, reset values and timing counts of the move planner
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_STATUS 8'h04
`define PMC_OFS_POSCMD 8'h08
`define PMC_OFS_SCALE 8'h0C
`define PMC_OFS_OVRD 8'h10
`define PMC_OFS_VELFWD 8'h14
`define PMC_OFS_VELREV 8'h18
`define PMC_OFS_ACCEL 8'h1C
`define PMC_OFS_POSOUT 8'h20
`define PMC_OFS_VELOUT 8'h24
`define PMC_OFS_ACTUAL 8'h28

`define PMC_CTRL_RST 16'h0000
`define PMC_CTRL_MASK 16'h03F7
`define PMC_SCALE_RST 32'h0001_0000
`define PMC_SCALE_FRAC 16
`define PMC_OVRD_RST 32'h0000_0100
`define PMC_OVRD_FRAC 8
`define PMC_VEL_RST 32'h0000_1000
`define PMC_ACCEL_RST 32'h0000_0010
`define PMC_JERK_SHIFT 2
`define PMC_SCAN_CYCLES 200

`endif

// ### rtl/pmc_pkg.sv
// types shared by the move planner modules
package pmc_pkg;

    typedef enum logic [1:0] {
        PMC_MODE_OFFSET = 2'h0,
        PMC_MODE_ABS = 2'h1,
        PMC_MODE_INC = 2'h2,
        PMC_MODE_IMM = 2'h3
    } pmc_mode_t;

    typedef enum logic [1:0] {
        PMC_PH_IDLE = 2'h0,
        PMC_PH_ACCEL = 2'h1,
        PMC_PH_CRUISE = 2'h3,
        PMC_PH_DECEL = 2'h2
    } pmc_phase_t;

    typedef struct packed {
        logic [5:0] unused;
        logic realign;
        logic pause;
        logic condHold;
        logic sCurve;
        logic overrideEn;
        logic scaleEn;
        logic reserved;
        logic start;
        logic [1:0] mode;
    } pmc_ctrl_t;

    typedef struct packed {
        logic [2:0] unused;
        logic running;
        logic done;
        logic zeroSpeed;
        logic realign;
        logic pause;
        logic condHold;
        logic sCurve;
        logic overrideEn;
        logic scaleEn;
        logic reserved;
        logic startAck;
        logic [1:0] mode;
    } pmc_status_t;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] velFwd;
        logic [31:0] velRev;
        logic [31:0] accel;
        logic pause;
        logic sCurve;
    } pmc_prof_cmd_t;

endpackage

// ### rtl/pmc_profile_gen.sv
// trapezoid or s-curve position profile, one step per scan tick
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_profile_gen #(
    parameter int JERK_SHIFT = `PMC_JERK_SHIFT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stepEn,
    input wire logic loadEn,
    input wire logic [31:0] loadPos,
    input wire pmc_pkg::pmc_prof_cmd_t cmd,
    output logic signed [31:0] pos,
    output logic signed [31:0] vel,
    output logic atTarget,
    output logic velZero,
    output pmc_pkg::pmc_phase_t phase
);

    logic signed [31:0] remain;
    logic signed [31:0] desired;
    logic signed [31:0] velNext;
    logic signed [31:0] accSigned;
    logic [31:0] remMag;
    logic [31:0] velMag;
    logic [31:0] velNextMag;
    logic [31:0] accStep;
    logic [31:0] jerk;
    logic [31:0] accCur;
    logic [63:0] velSq;
    logic [63:0] brakeDist;
    logic brake;
    logic snap;
    pmc_pkg::pmc_phase_t phaseNext;

    always_comb begin
        remain = $signed(cmd.target) - pos;
        remMag = remain[31] ? 32'(-remain) : 32'(remain);
        velMag = vel[31] ? 32'(-vel) : 32'(vel);
        velSq = 64'(velMag) * 64'(velMag);
        brakeDist = (64'(cmd.accel) * 64'(remMag)) << 1;
        brake = velSq >= brakeDist;
        jerk = cmd.accel >> JERK_SHIFT;
        if (jerk == 32'h0) begin
            jerk = 32'h1;
        end
        accStep = cmd.sCurve ? accCur : cmd.accel;
        accSigned = $signed(accStep);
        // pause brakes at the same rate as an arrival, but never snaps onto the target
        if (cmd.pause || brake) begin
            desired = 32'sh0;
        end else if (remain > 0) begin
            desired = $signed(cmd.velFwd);
        end else if (remain < 0) begin
            desired = -$signed(cmd.velRev);
        end else begin
            desired = 32'sh0;
        end
        if (vel < desired) begin
            velNext = (desired - vel > accSigned) ? vel + accSigned : desired;
        end else if (vel > desired) begin
            velNext = (vel - desired > accSigned) ? vel - accSigned : desired;
        end else begin
            velNext = vel;
        end
        velNextMag = velNext[31] ? 32'(-velNext) : 32'(velNext);
        snap = !cmd.pause && remMag <= velNextMag;
        if (velNextMag == velMag) begin
            phaseNext = (velNext == 32'sh0) ? pmc_pkg::PMC_PH_IDLE : pmc_pkg::PMC_PH_CRUISE;
        end else if (velNextMag > velMag) begin
            phaseNext = pmc_pkg::PMC_PH_ACCEL;
        end else begin
            phaseNext = pmc_pkg::PMC_PH_DECEL;
        end
        atTarget = (remain == 32'sh0) && (vel == 32'sh0);
        velZero = vel == 32'sh0;
    end

    // trapezoid when accel jumps, s-curve when it ramps by jerk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pos <= 32'sh0;
            vel <= 32'sh0;
            accCur <= 32'h0;
            phase <= pmc_pkg::PMC_PH_IDLE;
        end else if (loadEn) begin
            pos <= $signed(loadPos);
            vel <= 32'sh0;
            accCur <= 32'h0;
            phase <= pmc_pkg::PMC_PH_IDLE;
        end else if (stepEn) begin
            phase <= snap ? pmc_pkg::PMC_PH_IDLE : phaseNext;
            if (phaseNext != phase) begin
                accCur <= jerk;
            end else if (accCur + jerk < cmd.accel) begin
                accCur <= accCur + jerk;
            end else begin
                accCur <= cmd.accel;
            end
            if (snap) begin
                pos <= $signed(cmd.target);
                vel <= 32'sh0;
            end else begin
                pos <= pos + velNext;
                vel <= velNext;
            end
        end
    end

endmodule

// ### rtl/pmc_move_planner.sv
// point move command interpreter with APB control and status words
// Notes on behaviour
// - control bit 4 scales command into counts
// - start acts on rising edge only
// - bit 5 multiplies both velocity limits
// - bit 6 rounds profile into S shape
// - bit 7 freezes integrator on reference change
// - bit 8 pauses to controlled stop, resumes
// - bit 9 forces output to actual position
// - realign automatically on run rising edge
// - offset mode latches first command, adds differences
// - offset mode stays still when enabled
// - absolute mode moves on each start edge
// - absolute target comes from the scaled position command
// - incremental mode advances output by increment
// - status bits 0-9 acknowledge control functions
// - status 10 when profile velocity zero
// - status 11 when move finished at target
// - status 12 run; entry triggers realign
// - profile is trapezoidal or S-curve
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_move_planner #(
    parameter int SCAN_CYCLES = `PMC_SCAN_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic driveEnable,
    input wire logic positionEnable,
    input wire logic [31:0] actualPos,
    output logic [31:0] posRefOut,
    output logic [31:0] velRefOut,
    output logic integFreeze,
    output logic runStatus
);

    localparam int CNT_W = (SCAN_CYCLES > 1) ? $clog2(SCAN_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(SCAN_CYCLES - 1);

    pmc_pkg::pmc_ctrl_t ctrl_reg;
    pmc_pkg::pmc_status_t status;
    pmc_pkg::pmc_mode_t mode;
    pmc_pkg::pmc_prof_cmd_t profCmd;
    pmc_pkg::pmc_phase_t phase;

    logic [31:0] cmdPos_reg;
    logic [31:0] scale_reg;
    logic [31:0] ovrd_reg;
    logic [31:0] velFwd_reg;
    logic [31:0] velRev_reg;
    logic [31:0] accel_reg;
    logic cmdPend_reg;
    logic [31:0] target_reg;
    logic [31:0] offset_reg;
    logic [31:0] base_reg;
    logic offsetValid_reg;
    logic startPrev_reg;
    logic [1:0] enSync_reg;
    logic [1:0] peSync_reg;
    logic runPrev_reg;
    logic realignStat_reg;
    logic startAck_reg;
    logic moving_reg;
    logic done_reg;
    logic [31:0] posPrev_reg;
    logic [CNT_W-1:0] scanCnt_reg;
    logic scanTick_reg;

    logic access;
    logic xfer;
    logic wrEn;
    logic hit;
    logic [31:0] rdVal;
    logic [63:0] scaleProd;
    logic [31:0] scaledCmd;
    logic [63:0] fwdProd;
    logic [63:0] revProd;
    logic running;
    logic runRise;
    logic startRise;
    logic realignNow;
    logic moveGo;
    logic signed [31:0] profPos;
    logic signed [31:0] profVel;
    logic atTarget;
    logic velZero;

    // apb: one wait state so read data comes from a flop
    assign access = psel & penable;
    assign xfer = access & pready;
    assign wrEn = xfer & pwrite & hit;

    always_comb begin
        hit = 1'b1;
        rdVal = 32'h0;
        case (paddr)
            `PMC_OFS_CTRL: begin
                rdVal = {16'h0, ctrl_reg};
            end
            `PMC_OFS_STATUS: begin
                rdVal = {16'h0, status};
            end
            `PMC_OFS_POSCMD: begin
                rdVal = cmdPos_reg;
            end
            `PMC_OFS_SCALE: begin
                rdVal = scale_reg;
            end
            `PMC_OFS_OVRD: begin
                rdVal = ovrd_reg;
            end
            `PMC_OFS_VELFWD: begin
                rdVal = velFwd_reg;
            end
            `PMC_OFS_VELREV: begin
                rdVal = velRev_reg;
            end
            `PMC_OFS_ACCEL: begin
                rdVal = accel_reg;
            end
            `PMC_OFS_POSOUT: begin
                rdVal = posRefOut;
            end
            `PMC_OFS_VELOUT: begin
                rdVal = velRefOut;
            end
            `PMC_OFS_ACTUAL: begin
                rdVal = actualPos;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~hit;
            if (access && !pready) begin
                prdata <= pwrite ? 32'h0 : rdVal;
            end
        end
    end

    // software registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= `PMC_CTRL_RST;
            cmdPos_reg <= 32'h0;
            scale_reg <= `PMC_SCALE_RST;
            ovrd_reg <= `PMC_OVRD_RST;
            velFwd_reg <= `PMC_VEL_RST;
            velRev_reg <= `PMC_VEL_RST;
            accel_reg <= `PMC_ACCEL_RST;
        end else if (wrEn) begin
            case (paddr)
                `PMC_OFS_CTRL: begin
                    ctrl_reg <= pwdata[15:0] & `PMC_CTRL_MASK;
                end
                `PMC_OFS_POSCMD: begin
                    cmdPos_reg <= pwdata;
                end
                `PMC_OFS_SCALE: begin
                    scale_reg <= pwdata;
                end
                `PMC_OFS_OVRD: begin
                    ovrd_reg <= pwdata;
                end
                `PMC_OFS_VELFWD: begin
                    velFwd_reg <= pwdata;
                end
                `PMC_OFS_VELREV: begin
                    velRev_reg <= pwdata;
                end
                `PMC_OFS_ACCEL: begin
                    accel_reg <= pwdata;
                end
                default: begin
                end
            endcase
        end
    end

    // a command write is applied once, the cycle after it lands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmdPend_reg <= 1'b0;
        end else begin
            cmdPend_reg <= wrEn && (paddr == `PMC_OFS_POSCMD);
        end
    end

    // scan-rate enable for the profile step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scanCnt_reg <= '0;
            scanTick_reg <= 1'b0;
        end else begin
            scanTick_reg <= scanCnt_reg == CNT_TOP;
            scanCnt_reg <= (scanCnt_reg == CNT_TOP) ? '0 : scanCnt_reg + 1'b1;
        end
    end

    // enables arrive from pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enSync_reg <= 2'h0;
            peSync_reg <= 2'h0;
            runPrev_reg <= 1'b0;
        end else begin
            enSync_reg <= {enSync_reg[0], driveEnable};
            peSync_reg <= {peSync_reg[0], positionEnable};
            runPrev_reg <= running;
        end
    end

    assign running = enSync_reg[1] & peSync_reg[1];
    assign runRise = running & ~runPrev_reg;
    assign realignNow = ctrl_reg.realign | runRise;
    assign startRise = ctrl_reg.start & ~startPrev_reg;
    assign mode = pmc_pkg::pmc_mode_t'(ctrl_reg.mode);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startPrev_reg <= 1'b0;
        end else begin
            startPrev_reg <= ctrl_reg.start;
        end
    end

    // input scaling, product in fixed point
    always_comb begin
        scaleProd = 64'($signed(cmdPos_reg)) * 64'($signed(scale_reg));
        if (ctrl_reg.scaleEn) begin
            scaledCmd = scaleProd[`PMC_SCALE_FRAC +: 32];
        end else begin
            scaledCmd = cmdPos_reg;
        end
    end

    always_comb begin
        moveGo = 1'b0;
        if (!realignNow) begin
            case (mode)
                pmc_pkg::PMC_MODE_OFFSET: begin
                    moveGo = cmdPend_reg & offsetValid_reg;
                end
                pmc_pkg::PMC_MODE_ABS: begin
                    moveGo = startRise;
                end
                pmc_pkg::PMC_MODE_INC: begin
                    moveGo = startRise;
                end
                pmc_pkg::PMC_MODE_IMM: begin
                    moveGo = cmdPend_reg;
                end
                default: begin
                    moveGo = 1'b0;
                end
            endcase
        end
    end

    // interpreter: decides target from mode and events
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            target_reg <= 32'h0;
            offset_reg <= 32'h0;
            base_reg <= 32'h0;
            offsetValid_reg <= 1'b0;
        end else if (realignNow) begin
            target_reg <= actualPos;
            offsetValid_reg <= 1'b0;
        end else begin
            case (mode)
                pmc_pkg::PMC_MODE_OFFSET: begin
                    if (cmdPend_reg && !offsetValid_reg) begin
                        offset_reg <= scaledCmd;
                        base_reg <= profPos;
                        target_reg <= profPos;
                        offsetValid_reg <= 1'b1;
                    end else if (cmdPend_reg) begin
                        target_reg <= base_reg + scaledCmd - offset_reg;
                    end
                end
                pmc_pkg::PMC_MODE_ABS: begin
                    if (startRise) begin
                        target_reg <= scaledCmd;
                    end
                end
                pmc_pkg::PMC_MODE_INC: begin
                    if (startRise) begin
                        target_reg <= profPos + scaledCmd;
                    end
                end
                pmc_pkg::PMC_MODE_IMM: begin
                    if (cmdPend_reg) begin
                        target_reg <= scaledCmd;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // start acknowledge holds until software drops start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startAck_reg <= 1'b0;
        end else if (moveGo && startRise) begin
            startAck_reg <= 1'b1;
        end else if (!ctrl_reg.start) begin
            startAck_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            moving_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (moveGo || realignNow) begin
            moving_reg <= moveGo;
            done_reg <= 1'b0;
        end else if (moving_reg && atTarget) begin
            moving_reg <= 1'b0;
            done_reg <= 1'b1;
        end
    end

    // override applies to both limits
    always_comb begin
        fwdProd = 64'(velFwd_reg) * 64'(ovrd_reg);
        revProd = 64'(velRev_reg) * 64'(ovrd_reg);
        profCmd.target = target_reg;
        profCmd.velFwd = ctrl_reg.overrideEn ? fwdProd[`PMC_OVRD_FRAC +: 32] : velFwd_reg;
        profCmd.velRev = ctrl_reg.overrideEn ? revProd[`PMC_OVRD_FRAC +: 32] : velRev_reg;
        profCmd.accel = accel_reg;
        profCmd.pause = ctrl_reg.pause;
        profCmd.sCurve = ctrl_reg.sCurve;
    end

    pmc_profile_gen #(
        .JERK_SHIFT(`PMC_JERK_SHIFT)
    ) profile (
        .clk(clk),
        .sys_rst(sys_rst),
        .stepEn(scanTick_reg),
        .loadEn(realignNow),
        .loadPos(actualPos),
        .cmd(profCmd),
        .pos(profPos),
        .vel(profVel),
        .atTarget(atTarget),
        .velZero(velZero),
        .phase(phase)
    );

    always_comb begin
        status = '0;
        status.mode = ctrl_reg.mode;
        status.startAck = startAck_reg;
        status.scaleEn = ctrl_reg.scaleEn;
        status.overrideEn = ctrl_reg.overrideEn;
        status.sCurve = ctrl_reg.sCurve;
        status.condHold = ctrl_reg.condHold;
        status.pause = ctrl_reg.pause && phase != pmc_pkg::PMC_PH_ACCEL;
        status.realign = realignStat_reg;
        status.zeroSpeed = velZero;
        status.done = done_reg;
        status.running = runStatus;
    end

    // outputs, all from flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            posRefOut <= 32'h0;
            velRefOut <= 32'h0;
            posPrev_reg <= 32'h0;
            integFreeze <= 1'b0;
            runStatus <= 1'b0;
            realignStat_reg <= 1'b0;
        end else begin
            posRefOut <= profPos;
            velRefOut <= profVel;
            posPrev_reg <= profPos;
            integFreeze <= ctrl_reg.condHold && (profPos != posPrev_reg);
            runStatus <= running;
            realignStat_reg <= realignNow;
        end
    end

endmodule

// ### verification/pmc_move_planner_properties.sv
// port-level assertions for the move planner
`timescale 1ns/1ps
module pmc_move_planner_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic driveEnable,
    input wire logic positionEnable,
    input wire logic [31:0] actualPos,
    input wire logic [31:0] posRefOut,
    input wire logic [31:0] velRefOut,
    input wire logic integFreeze,
    input wire logic runStatus
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    a_err_only: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("read data on refused access");
    a_run_on: assert property ((driveEnable && positionEnable)[*5] |-> runStatus)
        else $error("run status missing");
    a_run_off: assert property ((!driveEnable)[*5] |-> !runStatus)
        else $error("run status without enable");
    a_realign_pos: assert property ($rose(runStatus) && $stable(actualPos) |-> ##[1:3] posRefOut == actualPos)
        else $error("no realign on run entry");
    a_freeze_move: assert property (integFreeze |-> posRefOut != $past(posRefOut) ||
        $past(posRefOut) != $past(posRefOut, 2) || $past(posRefOut, 2) != $past(posRefOut, 3))
        else $error("freeze without reference change");

    c_run: cover property ($rose(runStatus));
    c_refused: cover property (pready && pslverr);
    c_freeze: cover property ($rose(integFreeze));
endmodule

bind pmc_move_planner pmc_move_planner_properties i_props (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .driveEnable(driveEnable),
    .positionEnable(positionEnable), .actualPos(actualPos), .posRefOut(posRefOut),
    .velRefOut(velRefOut), .integFreeze(integFreeze), .runStatus(runStatus));

// ### verification/pmc_move_planner_tb.sv
// self-checking bench for the move planner
`timescale 1ns/1ps
`include "pmc_params.svh"
module pmc_move_planner_tb;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic [31:0] m;
        logic e;
    } pmc_row_t;
    localparam logic [31:0] allOnes = 32'hFFFF_FFFF;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, ev, hit;
    logic driveEnable, positionEnable, integFreeze, runStatus;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, actualPos, posRefOut, velRefOut, rv;
    int err_total = 0;
    int check_count = 0;
    pmc_row_t rows[14] = '{
        '{1'h0, `PMC_OFS_CTRL, 32'h0, 32'h0, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_SCALE, 32'h0, 32'h1_0000, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_OVRD, 32'h0, 32'h100, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_VELFWD, 32'h0, 32'h1000, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_VELREV, 32'h0, 32'h1000, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_ACCEL, 32'h0, 32'h10, allOnes, 1'h0},
        '{1'h1, `PMC_OFS_CTRL, 32'hFFFF, 32'h0, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_CTRL, 32'h0, 32'h3F7, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_STATUS, 32'h0, 32'h3F3, 32'h3FF, 1'h0},
        '{1'h1, `PMC_OFS_STATUS, 32'hFFFF, 32'h0, allOnes, 1'h0},
        '{1'h0, `PMC_OFS_STATUS, 32'h0, 32'h3F3, 32'h3FF, 1'h0},
        '{1'h1, `PMC_OFS_CTRL, 32'h0, 32'h0, allOnes, 1'h0},
        '{1'h0, 8'h2C, 32'h0, 32'h0, allOnes, 1'h1},
        '{1'h1, 8'h40, 32'h5A, 32'h0, allOnes, 1'h1}
    };

    pmc_move_planner #(.SCAN_CYCLES(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .driveEnable(driveEnable),
        .positionEnable(positionEnable), .actualPos(actualPos), .posRefOut(posRefOut),
        .velRefOut(velRefOut), .integFreeze(integFreeze), .runStatus(runStatus));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, s, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rv = prdata;
        ev = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            err_total++;
            test_done();
        end
        @(posedge clk);
    endtask

    // poll status until the move reports completion
    task automatic done_wait;
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'h0, `PMC_OFS_STATUS, 32'h0);
            if (rv[11] === 1'h1) break;
        end
        chk({30'h0, rv[11:10]}, 32'h3);
        if (n == 300) test_done();
        repeat (2) @(posedge clk);
    endtask

    task automatic wait_sig(input int k);
        hit = 1'h0;
        for (int n = 0; n < 200 && !hit; n++) begin
            @(posedge clk);
            hit = ((k == 0) ? runStatus : integFreeze) === 1'h1;
        end
        if (!hit) begin
            err_total++;
            test_done();
        end
    endtask

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        sys_rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        driveEnable = 1'h0;
        positionEnable = 1'h0;
        actualPos = 32'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        chk({posRefOut[30:0], runStatus}, 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(rv & rows[i].m, rows[i].x);
            chk({31'h0, ev}, {31'h0, rows[i].e});
        end
        actualPos <= 32'h100;
        driveEnable <= 1'h1;
        positionEnable <= 1'h1;
        wait_sig(0);
        repeat (3) @(posedge clk);
        chk(posRefOut, 32'h100);
        apb(1'h0, `PMC_OFS_STATUS, 32'h0);
        chk({31'h0, rv[12]}, 32'h1);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h128);
        apb(1'h1, `PMC_OFS_CTRL, 32'h1);
        apb(1'h1, `PMC_OFS_CTRL, 32'h5);
        done_wait();
        chk({31'h0, rv[2]}, 32'h1);
        chk(posRefOut, 32'h128);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h200);
        repeat (40) @(posedge clk);
        chk(posRefOut, 32'h128);
        apb(1'h1, `PMC_OFS_CTRL, 32'h1);
        apb(1'h1, `PMC_OFS_CTRL, 32'h5);
        done_wait();
        chk(posRefOut, 32'h200);
        apb(1'h1, `PMC_OFS_CTRL, 32'h2);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h10);
        apb(1'h1, `PMC_OFS_CTRL, 32'h6);
        done_wait();
        chk(posRefOut, 32'h210);
        apb(1'h1, `PMC_OFS_CTRL, 32'h3);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h180);
        done_wait();
        chk(posRefOut, 32'h180);
        apb(1'h1, `PMC_OFS_SCALE, 32'h2_0000);
        apb(1'h1, `PMC_OFS_CTRL, 32'h13);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h50);
        done_wait();
        chk(posRefOut, 32'hA0);
        apb(1'h1, `PMC_OFS_CTRL, 32'h113);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h400);
        repeat (40) @(posedge clk);
        chk(posRefOut, 32'hA0);
        chk(velRefOut, 32'h0);
        apb(1'h1, `PMC_OFS_CTRL, 32'h13);
        done_wait();
        chk(posRefOut, 32'h800);
        apb(1'h1, `PMC_OFS_CTRL, 32'h93);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h500);
        wait_sig(1);
        chk({31'h0, hit}, 32'h1);
        done_wait();
        chk(posRefOut, 32'hA00);
        chk(velRefOut, 32'h0);
        // override of 2.0 on a forward limit of 8 gives 16 counts per tick
        apb(1'h1, `PMC_OFS_OVRD, 32'h200);
        apb(1'h1, `PMC_OFS_VELFWD, 32'h8);
        apb(1'h1, `PMC_OFS_CTRL, 32'h23);
        apb(1'h1, `PMC_OFS_POSCMD, 32'hC00);
        repeat (20) @(posedge clk);
        chk(velRefOut, 32'h10);
        actualPos <= 32'h333;
        apb(1'h1, `PMC_OFS_CTRL, 32'h200);
        repeat (4) @(posedge clk);
        chk(posRefOut, 32'h333);
        apb(1'h1, `PMC_OFS_CTRL, 32'h0);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h1000);
        repeat (40) @(posedge clk);
        chk(posRefOut, 32'h333);
        apb(1'h1, `PMC_OFS_POSCMD, 32'h1010);
        done_wait();
        chk(posRefOut, 32'h343);
        driveEnable <= 1'h0;
        repeat (6) @(posedge clk);
        chk({31'h0, runStatus}, 32'h0);
        // second reset after run status has dropped
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        chk({posRefOut[30:0], runStatus}, 32'h0);
        apb(1'h0, `PMC_OFS_CTRL, 32'h0);
        chk(rv, 32'h0);
        test_done();
    end
endmodule
